// ==== hdl/bbs_hdr_mux.sv ====
// Purpose: picks one byte of the segment header by its index
// Assumes: index below the header length chosen by the caller
// Notes: purely combinational; the caller registers the byte
`timescale 1ns/1ps
module bbs_hdr_mux (
    input wire logic [4:0] idx,
    input wire logic marker,
    input wire logic ext,
    input wire logic [15:0] seq,
    input wire logic [31:0] ts,
    input wire logic [31:0] ssrc,
    input wire logic [31:0] ext_word,
    output logic [7:0] hdr_byte
);
    // ---------------------------------------------------------------
    // header layout, network byte order
    // ---------------------------------------------------------------
    always_comb begin
        case (idx)
            5'h00: hdr_byte = {bbs_pkg::RTP_VERSION, bbs_pkg::PADDING, ext,
                               bbs_pkg::CSRC_COUNT};
            5'h01: hdr_byte = {marker, bbs_pkg::PAYLOAD_TYPE};
            5'h02: hdr_byte = seq[15:8];
            5'h03: hdr_byte = seq[7:0];
            5'h04: hdr_byte = ts[31:24];
            5'h05: hdr_byte = ts[23:16];
            5'h06: hdr_byte = ts[15:8];
            5'h07: hdr_byte = ts[7:0];
            5'h08: hdr_byte = ssrc[31:24];
            5'h09: hdr_byte = ssrc[23:16];
            5'h0A: hdr_byte = ssrc[15:8];
            5'h0B: hdr_byte = ssrc[7:0];
            // extension right behind the ssrc field
            5'h0C: hdr_byte = ext_word[31:24];
            5'h0D: hdr_byte = ext_word[23:16];
            5'h0E: hdr_byte = ext_word[15:8];
            5'h0F: hdr_byte = ext_word[7:0];
            default: hdr_byte = 8'h00;
        endcase
    end
endmodule

// ==== hdl/bbs_pkg.sv ====
// Purpose: shared constants for the baseband packet segmenter
// Assumes: byte-wide streams, 32-bit register port
// Notes: offsets are byte addresses on the register port
package bbs_pkg;
    // ---------------------------------------------------------------
    // register map
    // ---------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_MTU = 8'h04;
    localparam logic [7:0] OFS_EXT_WORD = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_INT_STATUS = 8'h10;
    localparam logic [7:0] OFS_INT_MASK = 8'h14;
    localparam logic [7:0] OFS_SEQ = 8'h18;

    // field positions
    localparam int CTRL_EN_BIT = 0;
    localparam int INT_SEG_BIT = 0;
    localparam int INT_DONE_BIT = 1;
    localparam int INT_REFUSE_BIT = 2;
    localparam int INT_WIDTH = 3;

    // values after reset, and the mtu floor
    localparam logic [15:0] MTU_RESET = 16'h05DC;
    localparam logic [15:0] MTU_MIN = 16'h0040;
    localparam logic [31:0] EXT_WORD_RESET = 32'h0000_0000;
    localparam logic [15:0] SEQ_RESET = 16'h0000;
    localparam logic [2:0] INT_MASK_RESET = 3'h0;

    // ---------------------------------------------------------------
    // addressing and header constants
    // ---------------------------------------------------------------
    localparam logic [31:0] GROUP_ADDR = 32'hEF00_3330;
    localparam logic [15:0] PORT_BASE = 16'h7530;
    localparam logic [15:0] IP_UDP_RTP_BYTES = 16'h0028;
    localparam logic [15:0] IP_UDP_BYTES = 16'h001C;
    localparam logic [15:0] EXT_BYTES = 16'h0004;
    localparam logic [4:0] HDR_BYTES = 5'h0C;
    localparam logic [4:0] HDR_EXT_BYTES = 5'h10;
    localparam logic [1:0] RTP_VERSION = 2'h2;
    localparam logic [6:0] PAYLOAD_TYPE = 7'h4e;
    localparam logic [3:0] CSRC_COUNT = 4'h0;
    localparam logic PADDING = 1'b0;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_HDR = 2'b01,
        ST_PAY = 2'b10
    } bbs_state_type;
endpackage

// ==== hdl/bbs_segmenter.sv ====
// Purpose: cuts each baseband packet into segment packets with headers
// Assumes: source gives length, pipe and emission time with the start pulse
// Notes: one segment set in flight at a time; output stage is one register
`timescale 1ns/1ps

module bbs_segmenter (
    input wire logic clk,
    input wire logic nrst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq,
    // baseband packet source
    input wire logic bb_start,
    input wire logic [31:0] bb_len,
    input wire logic [5:0] bb_pipe,
    input wire logic [31:0] bb_sec,
    input wire logic [31:0] bb_nsec,
    input wire logic bb_signed,
    input wire logic [7:0] bb_data,
    input wire logic bb_valid,
    output logic bb_ready,
    // segment packet output
    output logic [7:0] out_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic out_first,
    output logic out_last,
    output logic [31:0] out_dst_addr,
    output logic [15:0] out_dst_port,
    output logic [15:0] out_len,
    output logic out_marker,
    output logic [15:0] out_seq,
    output logic [31:0] out_ts,
    output logic [31:0] out_ssrc,
    output logic out_ext
);
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    // payload room left by the mtu once all headers are counted
    function automatic logic [15:0] pay_room(input logic [15:0] mtu, input logic sgn);
        pay_room = mtu - bbs_pkg::IP_UDP_RTP_BYTES - (sgn ? bbs_pkg::EXT_BYTES : 16'h0000);
    endfunction

    function automatic logic [15:0] seg_size(input logic [31:0] rem, input logic [15:0] room);
        seg_size = (rem > {16'h0000, room}) ? room : rem[15:0];
    endfunction

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    bbs_pkg::bbs_state_type state_reg;
    logic [31:0] len_reg;
    logic [31:0] rem_reg;
    logic [15:0] seg_reg;
    logic [4:0] hdr_idx_reg;
    logic set_first_reg;
    logic [15:0] seq_reg;
    logic [31:0] ts_reg;
    logic [5:0] pipe_reg;
    logic signed_reg;
    logic ctrl_en_reg;
    logic [15:0] mtu_reg;
    logic [31:0] ext_word_reg;
    logic [2:0] int_status_reg;
    logic [2:0] int_mask_reg;
    logic [2:0] events;
    logic stage_free;
    logic hdr_emit;
    logic pay_emit;
    logic start_ok;
    logic seg_end;
    logic [4:0] hdr_len;
    logic [7:0] hdr_byte;
    logic [15:0] room;

    assign stage_free = !out_valid || out_ready;
    assign hdr_emit = (state_reg == bbs_pkg::ST_HDR) && stage_free;
    assign pay_emit = (state_reg == bbs_pkg::ST_PAY) && stage_free && bb_valid;
    assign bb_ready = (state_reg == bbs_pkg::ST_PAY) && stage_free;
    assign start_ok = bb_start && ctrl_en_reg && (state_reg == bbs_pkg::ST_IDLE)
                      && (bb_len != 32'h0000_0000);
    assign seg_end = pay_emit && (seg_reg == 16'h0001);
    assign hdr_len = signed_reg ? bbs_pkg::HDR_EXT_BYTES : bbs_pkg::HDR_BYTES;
    assign room = pay_room(mtu_reg, signed_reg);

    // ---------------------------------------------------------------
    // segment sequencer
    // ---------------------------------------------------------------
    // a start pulse is only taken when idle; the count of bytes left in the
    // set decides between a new header and going back to idle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= bbs_pkg::ST_IDLE;
            len_reg <= 32'h0000_0000;
            rem_reg <= 32'h0000_0000;
            seg_reg <= 16'h0000;
            hdr_idx_reg <= 5'h00;
            set_first_reg <= 1'b0;
            ts_reg <= 32'h0000_0000;
            pipe_reg <= 6'h00;
            signed_reg <= 1'b0;
        end else begin
            case (state_reg)
                bbs_pkg::ST_IDLE: begin
                    if (start_ok) begin
                        len_reg <= bb_len;
                        rem_reg <= bb_len;
                        seg_reg <= seg_size(bb_len, pay_room(mtu_reg, bb_signed));
                        hdr_idx_reg <= 5'h00;
                        set_first_reg <= 1'b1;
                        ts_reg <= {bb_sec[21:0], bb_nsec[29:20]};
                        pipe_reg <= bb_pipe;
                        signed_reg <= bb_signed;
                        state_reg <= bbs_pkg::ST_HDR;
                    end
                end
                bbs_pkg::ST_HDR: begin
                    if (hdr_emit) begin
                        if (hdr_idx_reg == hdr_len - 5'h01) begin
                            state_reg <= bbs_pkg::ST_PAY;
                        end else begin
                            hdr_idx_reg <= hdr_idx_reg + 5'h01;
                        end
                    end
                end
                bbs_pkg::ST_PAY: begin
                    if (pay_emit) begin
                        rem_reg <= rem_reg - 32'h0000_0001;
                        seg_reg <= seg_reg - 16'h0001;
                        if (seg_end) begin
                            set_first_reg <= 1'b0;
                            hdr_idx_reg <= 5'h00;
                            if (rem_reg == 32'h0000_0001) begin
                                state_reg <= bbs_pkg::ST_IDLE;
                            end else begin
                                seg_reg <= seg_size(rem_reg - 32'h0000_0001, room);
                                state_reg <= bbs_pkg::ST_HDR;
                            end
                        end
                    end
                end
                default: state_reg <= bbs_pkg::ST_IDLE;
            endcase
        end
    end

    // sequence number: one step per finished segment, software may preset it while idle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            seq_reg <= bbs_pkg::SEQ_RESET;
        end else if (seg_end) begin
            seq_reg <= seq_reg + 16'h0001;
        end else if (reg_wr && reg_addr == bbs_pkg::OFS_SEQ
                     && state_reg == bbs_pkg::ST_IDLE) begin
            seq_reg <= reg_wdata[15:0];
        end
    end

    bbs_hdr_mux u_hdr (
        .idx(hdr_idx_reg),
        .marker(set_first_reg),
        .ext(signed_reg),
        .seq(seq_reg),
        .ts(ts_reg),
        .ssrc(set_first_reg ? len_reg : 32'h0000_0000),
        .ext_word(ext_word_reg),
        .hdr_byte(hdr_byte)
    );

    // ---------------------------------------------------------------
    // output stage
    // ---------------------------------------------------------------
    // one register deep; holding back here stalls both header and payload
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            out_valid <= 1'b0;
            out_data <= 8'h00;
            out_first <= 1'b0;
            out_last <= 1'b0;
        end else if (stage_free) begin
            out_valid <= hdr_emit || pay_emit;
            out_data <= hdr_emit ? hdr_byte : bb_data;
            out_first <= hdr_emit && (hdr_idx_reg == 5'h00);
            out_last <= seg_end;
        end
    end

    // descriptor follows the first header byte so it never changes under
    // the tail of the previous segment
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            out_dst_port <= bbs_pkg::PORT_BASE;
            out_len <= 16'h0000;
            out_marker <= 1'b0;
            out_seq <= 16'h0000;
            out_ts <= 32'h0000_0000;
            out_ssrc <= 32'h0000_0000;
            out_ext <= 1'b0;
        end else if (hdr_emit && hdr_idx_reg == 5'h00) begin
            out_dst_port <= bbs_pkg::PORT_BASE + {10'h000, pipe_reg};
            out_len <= {11'h000, hdr_len} + seg_reg;
            out_marker <= set_first_reg;
            out_seq <= seq_reg;
            out_ts <= ts_reg;
            out_ssrc <= set_first_reg ? len_reg : 32'h0000_0000;
            out_ext <= signed_reg;
        end
    end

    assign out_dst_addr = bbs_pkg::GROUP_ADDR;

    // ---------------------------------------------------------------
    // registers and interrupt
    // ---------------------------------------------------------------
    // mtu clamps low so the payload room can never wrap below zero
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_en_reg <= 1'b0;
            mtu_reg <= bbs_pkg::MTU_RESET;
            ext_word_reg <= bbs_pkg::EXT_WORD_RESET;
            int_mask_reg <= bbs_pkg::INT_MASK_RESET;
        end else if (reg_wr) begin
            case (reg_addr)
                bbs_pkg::OFS_CTRL: ctrl_en_reg <= reg_wdata[bbs_pkg::CTRL_EN_BIT];
                bbs_pkg::OFS_MTU: mtu_reg <= (reg_wdata[15:0] < bbs_pkg::MTU_MIN) ?
                                             bbs_pkg::MTU_MIN : reg_wdata[15:0];
                bbs_pkg::OFS_EXT_WORD: ext_word_reg <= reg_wdata;
                bbs_pkg::OFS_INT_MASK: int_mask_reg <= reg_wdata[2:0];
                default: ;
            endcase
        end
    end

    always_comb begin
        events = 3'h0;
        events[bbs_pkg::INT_SEG_BIT] = seg_end;
        events[bbs_pkg::INT_DONE_BIT] = seg_end && (rem_reg == 32'h0000_0001);
        events[bbs_pkg::INT_REFUSE_BIT] = bb_start && !start_ok;
    end

    // read clears, a new event in the same cycle survives the clear
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            int_status_reg <= 3'h0;
        end else if (reg_rd && reg_addr == bbs_pkg::OFS_INT_STATUS) begin
            int_status_reg <= events;
        end else begin
            int_status_reg <= int_status_reg | events;
        end
    end

    assign irq = |(int_status_reg & int_mask_reg);

    // read data stand in the cycle after the strobe only
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                bbs_pkg::OFS_CTRL: reg_rdata <= {31'h0000_0000, ctrl_en_reg};
                bbs_pkg::OFS_MTU: reg_rdata <= {16'h0000, mtu_reg};
                bbs_pkg::OFS_EXT_WORD: reg_rdata <= ext_word_reg;
                bbs_pkg::OFS_STATUS: reg_rdata <= {14'h0000, state_reg, seq_reg};
                bbs_pkg::OFS_INT_STATUS: reg_rdata <= {29'h0000_0000, int_status_reg};
                bbs_pkg::OFS_INT_MASK: reg_rdata <= {29'h0000_0000, int_mask_reg};
                bbs_pkg::OFS_SEQ: reg_rdata <= {16'h0000, seq_reg};
                default: reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    // helpers: byte position in a segment, last accepted seq and timestamp
    logic [4:0] pos_reg;
    logic [15:0] last_seq_reg;
    logic [31:0] last_ts_reg;
    logic seen_reg;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pos_reg <= 5'h00;
            last_seq_reg <= 16'h0000;
            last_ts_reg <= 32'h0000_0000;
            seen_reg <= 1'b0;
        end else if (out_valid && out_ready) begin
            pos_reg <= out_last ? 5'h00 : (pos_reg == 5'h1F ? pos_reg : pos_reg + 5'h01);
            if (out_last) begin
                last_seq_reg <= out_seq;
                last_ts_reg <= out_ts;
                seen_reg <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_dst_port: assert property (out_valid |-> out_dst_port == 16'h7530 + {10'h000, pipe_reg}
        && out_dst_addr == 32'hEF00_3330) else $error("bad destination");
    a_seg_fits: assert property (out_valid |-> out_len + 16'h001C <= mtu_reg)
        else $error("segment over mtu");
    a_marker_cont: assert property (out_valid && out_first && seen_reg && !out_marker
        |-> out_ts == last_ts_reg) else $error("timestamp changed in set");
    a_ssrc_rule: assert property (out_valid |-> (out_marker ? out_ssrc == len_reg
        : out_ssrc == 32'h0000_0000)) else $error("ssrc wrong");
    a_hdr_byte0: assert property (out_valid && out_first |-> out_data == {2'b10, 1'b0,
        out_ext, 4'h0}) else $error("first header byte wrong");
    a_ext_hdr_len: assert property (out_valid && out_first |-> out_ext == signed_reg
        && out_len > (out_ext ? 16'h0010 : 16'h000C)) else $error("ext bit wrong");
    a_pt_marker: assert property (out_valid && pos_reg == 5'h01 |-> out_data ==
        {out_marker, 7'h4e}) else $error("payload type or marker wrong");
    a_seq_step: assert property (out_valid && out_first && seen_reg |-> out_seq ==
        last_seq_reg + 16'h0001) else $error("sequence skipped");
    a_ts_build: assert property (start_ok ##1 1'b1 |-> ts_reg ==
        {$past(bb_sec[21:0]), $past(bb_nsec[29:20])}) else $error("timestamp bits");
    a_marker_once: assert property (seg_end && rem_reg != 32'h0000_0001 |=> !set_first_reg
        [*2]) else $error("marker on continuation");

    c_multi_seg: cover property (out_valid && out_first && !out_marker);
    c_signed: cover property (out_valid && out_first && out_ext);
    c_irq: cover property (irq);
endmodule

// ==== testbench/bbs_consumer.sv ====
// Purpose: far-side consumer that rebuilds baseband packets from segments
// Assumes: segments arrive on the byte stream of the segmenter
// Notes: slow mode drops ready one cycle in four to stall the sender
`timescale 1ns/1ps
module bbs_consumer (
    input wire logic clk,
    input wire logic nrst,
    input wire logic slow,
    input wire logic [7:0] out_data,
    input wire logic out_valid,
    output logic out_ready,
    input wire logic out_first,
    input wire logic out_marker,
    input wire logic [15:0] out_seq,
    input wire logic [31:0] out_ssrc,
    input wire logic out_ext,
    output int n_done,
    output int n_drop
);
    logic [1:0] stall_cnt;
    logic [15:0] next_seq;
    logic busy;
    int idx, got, need;
    // ready pattern: prompt, or slow to exercise back-pressure
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stall_cnt <= 2'h0;
            out_ready <= 1'b0;
        end else begin
            stall_cnt <= stall_cnt + 2'h1;
            out_ready <= !slow || (stall_cnt != 2'h3);
        end
    end
    // gather payload up to the signalled length; a gap or early marker loses it
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            busy = 1'b0;
            n_done = 0;
            n_drop = 0;
        end else if (out_valid && out_ready) begin
            if (out_first) begin
                idx = 0;
                if (busy && (out_marker || out_seq !== next_seq)) begin
                    n_drop = n_drop + 1;
                    busy = 1'b0;
                end
                if (out_marker) begin
                    busy = 1'b1;
                    got = 0;
                    need = out_ssrc;
                end
                next_seq = out_seq + 16'h0001;
            end
            if (busy && idx >= (out_ext ? 16 : 12)) got = got + 1;
            if (busy && got == need) begin
                n_done = n_done + 1;
                busy = 1'b0;
            end
            idx = idx + 1;
        end
    end
endmodule

// ==== testbench/tb_top.sv ====
// Purpose: self-checking bench for the baseband packet segmenter
// Assumes: 125 MHz clock, active-low asynchronous reset
// Notes: a byte monitor judges every segment against the source values
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, irq, slow = 1'b0;
    logic [7:0] reg_addr = 8'h00, bb_data = 8'h00, out_data;
    logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, d;
    logic bb_start = 1'b0, bb_signed = 1'b0, bb_valid = 1'b0, bb_ready;
    logic [31:0] bb_len = 32'h0000_0000, bb_sec = 32'h0000_0000, bb_nsec = 32'h0000_0000;
    logic [5:0] bb_pipe = 6'h00;
    logic out_valid, out_ready, out_first, out_last, out_marker, out_ext, first_seg, exp_ext;
    logic [31:0] out_dst_addr, out_ts, out_ssrc, exp_ts, tot, ext_word;
    logic [15:0] out_dst_port, out_len, out_seq, exp_seq = 16'h0000;
    int n_fail = 0, num_checks = 0, cycles = 0, n_done, n_drop;
    int idx, rem, pay, lim, off, n_seg, hdr, exp_pipe;

    always #4 clk = ~clk;

    bbs_segmenter u_dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
        .bb_start(bb_start), .bb_len(bb_len), .bb_pipe(bb_pipe), .bb_sec(bb_sec),
        .bb_nsec(bb_nsec), .bb_signed(bb_signed), .bb_data(bb_data), .bb_valid(bb_valid),
        .bb_ready(bb_ready), .out_data(out_data), .out_valid(out_valid),
        .out_ready(out_ready), .out_first(out_first), .out_last(out_last),
        .out_dst_addr(out_dst_addr), .out_dst_port(out_dst_port), .out_len(out_len),
        .out_marker(out_marker), .out_seq(out_seq), .out_ts(out_ts), .out_ssrc(out_ssrc),
        .out_ext(out_ext));

    bbs_consumer u_cons (.clk(clk), .nrst(nrst), .slow(slow), .out_data(out_data),
        .out_valid(out_valid), .out_ready(out_ready), .out_first(out_first),
        .out_marker(out_marker), .out_seq(out_seq), .out_ssrc(out_ssrc), .out_ext(out_ext),
        .n_done(n_done), .n_drop(n_drop));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks = num_checks + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic reg_read(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        v = reg_rdata;
    endtask

    // start pulse alone, for refused starts
    task automatic poke(input logic [31:0] len);
        @(posedge clk);
        bb_len <= len;
        bb_start <= 1'b1;
        @(posedge clk);
        bb_start <= 1'b0;
        @(negedge clk);
    endtask

    // one baseband packet; payload byte k carries k, ready sampled mid-cycle
    task automatic send(input int len, input logic [5:0] p, input logic sgn,
                        input logic [31:0] sec, input logic [31:0] nsec);
        int i;
        logic hit;
        rem = len;
        tot = len;
        off = 0;
        n_seg = 0;
        first_seg = 1'b1;
        exp_ext = sgn;
        exp_pipe = p;
        lim = 64 - 40 - (sgn ? 4 : 0);
        exp_ts = {sec[21:0], nsec[29:20]};
        @(posedge clk);
        {bb_start, bb_len, bb_pipe, bb_signed, bb_sec, bb_nsec} <= {1'b1, tot, p, sgn, sec, nsec};
        @(posedge clk);
        bb_start <= 1'b0;
        bb_valid <= 1'b1;
        bb_data <= 8'h00;
        i = 0;
        while (i < len) begin
            @(negedge clk);
            hit = bb_ready;
            @(posedge clk);
            if (hit) begin
                i = i + 1;
                bb_data <= 8'(i);
                bb_valid <= (i < len);
            end
        end
    endtask

    task automatic wait_done(input int n);
        for (int k = 0; k < 3000 && n_done < n; k++) @(posedge clk);
        // step off the edge so the monitor has counted the final segment
        @(negedge clk);
        check(32'(n_done), 32'(n));
        check(32'(n_drop), 32'h0000_0000);
    endtask

    // ------------------------------------------------------------
    // segment monitor
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (nrst && out_valid === 1'b1 && out_ready === 1'b1) begin
            if (out_first === 1'b1) begin
                idx = 0;
                hdr = exp_ext ? 16 : 12;
                pay = (rem < lim) ? rem : lim;
                check(32'(out_marker), 32'(first_seg));
                check(out_ssrc, first_seg ? tot : 32'h0000_0000);
                check(out_ts, exp_ts);
                check(32'(out_ext), 32'(exp_ext));
                check(32'(out_seq), 32'(exp_seq));
                check(out_dst_addr, 32'hEF00_3330);
                check(32'(out_dst_port), 32'(30000 + exp_pipe));
                check(32'(out_len), 32'(pay + hdr));
            end
            if (idx == 0) check(32'(out_data), 32'({2'h2, 1'b0, exp_ext, 4'h0}));
            if (idx == 1) check(32'(out_data), 32'({first_seg, 7'h4e}));
            if (idx == 4) check(32'(out_data), 32'(exp_ts[31:24]));
            if (idx == 12 && exp_ext) check(32'(out_data), 32'(ext_word[31:24]));
            if (idx >= hdr) begin
                check(32'(out_data), 32'(off[7:0]));
                off = off + 1;
            end
            if (out_last === 1'b1) begin
                check(32'(idx + 1), 32'(hdr + pay));
                rem = rem - pay;
                exp_seq = exp_seq + 16'h0001;
                first_seg = 1'b0;
                n_seg = n_seg + 1;
            end
            idx = idx + 1;
        end
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        reg_read(bbs_pkg::OFS_MTU, d);
        check(d, 32'h0000_05DC);
        reg_read(bbs_pkg::OFS_INT_MASK, d);
        check(d, 32'h0000_0000);
        reg_read(bbs_pkg::OFS_SEQ, d);
        check(d, 32'h0000_0000);
        reg_read(8'h1C, d);
        check(d, 32'h0000_0000);
        reg_write(bbs_pkg::OFS_MTU, 32'h0000_0010);
        reg_read(bbs_pkg::OFS_MTU, d);
        check(d, 32'h0000_0040);
        $display("test regs done");
    endtask

    // 50 bytes at mtu 64 gives 24 + 24 + 2, prompt consumer
    task automatic t_split;
        reg_write(bbs_pkg::OFS_CTRL, 32'h0000_0001);
        send(50, 6'h3F, 1'b0, 32'h1234_5678, 32'h2ABC_DEF0);
        wait_done(1);
        check(32'(n_seg), 32'h0000_0003);
        reg_read(bbs_pkg::OFS_SEQ, d);
        check(d, 32'h0000_0003);
        reg_read(bbs_pkg::OFS_INT_STATUS, d);
        check(d, 32'h0000_0003);
        $display("test split done");
    endtask

    // signed: 30 bytes at 20 per segment, stalling consumer
    task automatic t_signed;
        ext_word = 32'hA5C3_0F1E;
        reg_write(bbs_pkg::OFS_EXT_WORD, ext_word);
        slow <= 1'b1;
        send(30, 6'h00, 1'b1, 32'hFFFF_FFFF, 32'h3B9A_C9FF);
        wait_done(2);
        check(32'(n_seg), 32'h0000_0002);
        $display("test signed done");
    endtask

    // refused starts raise the refuse event; mask gates the line
    task automatic t_irq;
        reg_read(bbs_pkg::OFS_INT_STATUS, d);
        reg_write(bbs_pkg::OFS_INT_MASK, 32'h0000_0004);
        reg_write(bbs_pkg::OFS_CTRL, 32'h0000_0000);
        poke(32'h0000_0008);
        check(32'(irq), 32'h0000_0001);
        reg_read(bbs_pkg::OFS_INT_STATUS, d);
        check(d, 32'h0000_0004);
        check(32'(irq), 32'h0000_0000);
        reg_write(bbs_pkg::OFS_CTRL, 32'h0000_0001);
        reg_write(bbs_pkg::OFS_INT_MASK, 32'h0000_0000);
        poke(32'h0000_0000);
        check(32'(irq), 32'h0000_0000);
        reg_read(bbs_pkg::OFS_INT_STATUS, d);
        check(d, 32'h0000_0004);
        // preset the sequence while idle, status shows idle state and new value
        reg_write(bbs_pkg::OFS_SEQ, 32'h0000_1234);
        reg_read(bbs_pkg::OFS_STATUS, d);
        check(d, 32'h0000_1234);
        $display("test irq done");
    endtask

    // watchdog: whole run is a few hundred cycles
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            n_fail = n_fail + 1;
            conclude();
        end
    end

    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        t_regs();
        t_split();
        t_signed();
        t_irq();
        conclude();
    end
endmodule
